// >>> ddr2_init_and_latency_config_tb.sv
// Self-checking bench for the command decoder and latency logic
`timescale 1ns/1ps
module ddr2_init_and_latency_config_tb
   import dilc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cke, cs_n, ras_n, cas_n, we_n, term;
   logic [2:0] ba;
   logic [15:0] addr;
   logic int_rd, rd_st, int_wr, wr_ex, pre_all, refr;
   logic dll_en, fast, cal_def, term_act, ready, cfg_err;
   logic [2:0] posted, lat;
   logic [3:0] total, wdel;
   int failures = 0;
   int n_tests = 0;
   int at[6];

   always #50 sys_clk = ~sys_clk;

   dilc_top u_dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .cke_i(cke), .cs_n_i(cs_n),
      .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr),
      .termination_control_i(term), .internal_read_o(int_rd), .internal_write_o(int_wr),
      .read_data_start_o(rd_st), .write_data_expect_o(wr_ex), .precharge_all_o(pre_all),
      .refresh_o(refr), .posted_delay_o(posted), .read_latency_o(lat),
      .total_read_delay_o(total), .write_delay_o(wdel), .dll_enable_o(dll_en),
      .refresh_rate_fast_o(fast), .driver_impedance_cal_default_o(cal_def),
      .termination_active_o(term_act), .init_ready_o(ready), .config_error_o(cfg_err));

   dilc_ctrl_model #(.CLK_NS(100)) u_ctrl (.sys_clk_i(sys_clk), .cke_o(cke), .cs_n_o(cs_n),
      .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr),
      .termination_control_o(term));

   task automatic chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         failures++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Edge, counted from the command edge, at which each strobe is first seen high
   task automatic watch();
      logic [5:0] s;
      for (int k = 0; k < 6; k++) at[k] = -1;
      for (int n = 0; n < 24; n++) begin
         @(negedge sys_clk);
         s = {int_rd, rd_st, int_wr, wr_ex, pre_all, refr};
         for (int k = 0; k < 6; k++) if (s[5-k] === 1'b1 && at[k] < 0) at[k] = n + 1;
      end
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
   endtask

   task automatic t_reset();
      @(negedge sys_clk);
      chk(posted === 3'h0 && lat === 3'h3 && total === 4'h3 && wdel === 4'h2, "rst lat");
      chk(dll_en === 1'b1 && ready === 1'b0 && cfg_err === 1'b0, "rst levels");
      chk(cal_def === 1'b0 && fast === 1'b0 && term_act === 1'b0, "rst cfg");
   endtask

   task automatic t_init();
      int n;
      n = -1;
      u_ctrl.power_up();
      u_ctrl.issue(CMD_PRECHARGE, 3'h0, 16'h0400);
      watch();
      chk(at[4] == 1, "precharge all");
      u_ctrl.load(3'h2, 16'h0080);
      chk(fast === 1'b1, "fast refresh");
      u_ctrl.load(3'h3, 16'h0000);
      u_ctrl.load(3'h1, 16'h0000);
      chk(dll_en === 1'b1 && cfg_err === 1'b0, "loop on");
      u_ctrl.issue(CMD_LOAD, 3'h0, 16'h0100);
      fork
         begin
            for (int k = 0; k < 300 && n < 0; k++) begin
               @(negedge sys_clk);
               if (ready === 1'b1) n = k + 1;
            end
         end
         begin
            u_ctrl.nops(2);
            u_ctrl.issue(CMD_PRECHARGE, 3'h0, 16'h0400);
            u_ctrl.issue(CMD_REFRESH, 3'h0, 16'h0000);
            watch();
            chk(at[5] == 1, "refresh");
            u_ctrl.issue(CMD_REFRESH, 3'h0, 16'h0000);
            u_ctrl.load(3'h0, 16'h0040);
            chk(lat === 3'h4, "op latency");
            u_ctrl.load(3'h1, 16'h0380);
            chk(cal_def === 1'b1 && cfg_err === 1'b0, "cal enter");
            u_ctrl.load(3'h1, 16'h0000);
            chk(cal_def === 1'b0 && dll_en === 1'b1, "cal exit");
         end
      join
      chk(n == 201, "ready wait");
      if (n < 0) report_and_stop();
   endtask

   task automatic t_latency();
      int p;
      int c;
      for (int i = 0; i < 7; i++) begin
         p = i;
         c = 3 + i % 5;
         u_ctrl.load(3'h0, 16'(c << 4));
         u_ctrl.load(3'h1, 16'(p << 3));
         chk(posted === 3'(p) && lat === 3'(c) && total === 4'(p + c), "fields");
         chk(wdel === 4'(p + c - 1), "write delay field");
         u_ctrl.issue(CMD_READ, 3'h0, 16'h0000);
         watch();
         chk(at[0] == p + 1 && at[1] == p + c, "read timing");
         u_ctrl.issue(CMD_WRITE, 3'h0, 16'h0000);
         watch();
         chk(at[2] == p + 1 && at[3] == p + c - 1, "write timing");
      end
      chk(cfg_err === 1'b0, "legal loads");
   endtask

   task automatic t_cke_low();
      u_ctrl.set_cke(1'b0);
      u_ctrl.issue(CMD_PRECHARGE, 3'h0, 16'h0400);
      watch();
      chk(at[4] < 0, "gated command");
      u_ctrl.set_cke(1'b1);
   endtask

   // Termination follows the pin only once the latency word enables it
   task automatic t_term();
      u_ctrl.set_term(1'b1);
      repeat (2) @(negedge sys_clk);
      chk(term_act === 1'b0, "termination while disabled");
      u_ctrl.set_term(1'b0);
      u_ctrl.load(3'h1, 16'h0004);
      u_ctrl.nops(8);
      u_ctrl.set_term(1'b1);
      repeat (2) @(negedge sys_clk);
      chk(term_act === 1'b1, "termination on");
      u_ctrl.set_term(1'b0);
      repeat (2) @(negedge sys_clk);
      chk(term_act === 1'b0, "termination off");
   endtask

   task automatic t_reserved();
      u_ctrl.load(3'h1, 16'h0010);
      u_ctrl.load(3'h1, 16'h0038);
      chk(posted === 3'h2 && cfg_err === 1'b1, "reserved posted");
      u_ctrl.load(3'h0, 16'h0020);
      chk(lat === 3'h4, "reserved latency");
      do_reset();
      @(negedge sys_clk);
      chk(cfg_err === 1'b0 && posted === 3'h0, "error cleared");
   endtask

   initial begin
      do_reset();
      t_reset();
      t_init();
      t_latency();
      t_cke_low();
      t_term();
      t_reserved();
      report_and_stop();
   end
endmodule

// >>> dilc_ctrl_model.sv
// Memory controller model that drives the device command pins
`timescale 1ns/1ps
module dilc_ctrl_model
   import dilc_pkg::*;
#(
   parameter int CLK_NS = 100
) (
   // Clock
   input wire logic sys_clk_i,
   // Command pins
   output logic cke_o,
   output logic cs_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic [2:0] ba_o,
   output logic [15:0] addr_o,
   output logic termination_control_o
);
   initial begin
      cke_o = 1'b0;
      cs_n_o = 1'b1;
      {ras_n_o, cas_n_o, we_n_o} = CMD_NOP;
      ba_o = 3'h0;
      addr_o = 16'h0000;
      termination_control_o = 1'b0;
   end
   // Deselected lines flip so a stale value never looks like a held one
   task automatic nops(input int n);
      repeat (n) begin
         @(posedge sys_clk_i);
         cs_n_o <= 1'b1;
         {ras_n_o, cas_n_o, we_n_o} <= CMD_NOP;
         ba_o <= ~ba_o;
         addr_o <= ~addr_o;
      end
   endtask
   task automatic issue(input dilc_cmd_e c, input logic [2:0] b, input logic [15:0] a);
      @(posedge sys_clk_i);
      cs_n_o <= 1'b0;
      {ras_n_o, cas_n_o, we_n_o} <= c;
      ba_o <= b;
      addr_o <= a;
      nops(1);
   endtask
   // Loads only while idle, then the mode-load gap
   task automatic load(input logic [2:0] b, input logic [15:0] a);
      issue(CMD_LOAD, b, a);
      nops(2);
   endtask
   task automatic set_cke(input logic v);
      @(posedge sys_clk_i);
      cke_o <= v;
   endtask
   task automatic set_term(input logic v);
      @(posedge sys_clk_i);
      termination_control_o <= v;
   endtask
   // Time waits become cycle counts, rounded up
   task automatic power_up();
      nops((200000 + CLK_NS - 1) / CLK_NS);
      set_cke(1'b1);
      nops((400 + CLK_NS - 1) / CLK_NS);
   endtask
endmodule

// >>> dilc_delay_line.sv
// Pulse delay line with two selectable taps
`timescale 1ns/1ps
module dilc_delay_line #(
   parameter int DEPTH = 16,
   parameter int TAP_W = 5
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // Pulse and tap selects
   input wire logic pulse_i,
   input wire logic [TAP_W-1:0] tap_a_i,
   input wire logic [TAP_W-1:0] tap_b_i,
   // Delayed pulses
   output logic out_a_o,
   output logic out_b_o
);
   logic [DEPTH-1:0] sr;
   logic [DEPTH-1:0] next_sr;
   logic out_a;
   logic out_b;
   logic next_out_a;
   logic next_out_b;

   // Tap 1 takes the live pulse so the output flop still lands on the tap edge
   function automatic logic pick(input logic [TAP_W-1:0] tap, input logic [DEPTH-1:0] s,
                                 input logic p);
      logic r;
      r = 1'b0;
      if (tap == TAP_W'(1)) begin
         r = p;
      end else if (tap >= TAP_W'(2) && int'(tap) <= DEPTH + 1) begin
         r = s[int'(tap) - 2];
      end
      return r;
   endfunction

   always_comb begin
      next_sr = {sr[DEPTH-2:0], pulse_i};
      next_out_a = pick(tap_a_i, sr, pulse_i);
      next_out_b = pick(tap_b_i, sr, pulse_i);
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sr <= '0;
         out_a <= 1'b0;
         out_b <= 1'b0;
      end else begin
         sr <= next_sr;
         out_a <= next_out_a;
         out_b <= next_out_b;
      end
   end

   assign out_a_o = out_a;
   assign out_b_o = out_b;
endmodule

// >>> dilc_pkg.sv
// Types shared by the configuration-load decoder and latency logic
package dilc_pkg;
   typedef enum logic [2:0] {
      CMD_LOAD = 3'h0,
      CMD_REFRESH = 3'h1,
      CMD_PRECHARGE = 3'h2,
      CMD_ACTIVATE = 3'h3,
      CMD_WRITE = 3'h4,
      CMD_READ = 3'h5,
      CMD_TERMINATE = 3'h6,
      CMD_NOP = 3'h7
   } dilc_cmd_e;
   typedef enum logic [1:0] {
      SEL_MAIN = 2'h0,
      SEL_LAT = 2'h1,
      SEL_REFR = 2'h2,
      SEL_SPARE = 2'h3
   } dilc_sel_e;
   typedef enum logic [1:0] {
      INIT_IDLE = 2'h0,
      INIT_LOCK = 2'h1,
      INIT_READY = 2'h2
   } dilc_init_e;
endpackage

// >>> dilc_regs.svh
// Constants for the configuration-load decoder and latency logic
// Behaviour
// - Posted delay in latency bits 3 to 5 selects 0 to 6 clocks.
// - Reads or writes are held posted delay plus one clocks before internal issue.
// - First read data comes posted delay plus read latency clocks after READ.
// - Write data is expected one clock earlier than read data would be.
// - Device is ready 200 clocks after the loop reset load, not before.
// - Precharge with bit 10 high hits all banks; bank lines pick the register.
// - Read latency in main bits 4 to 6 selects 3 to 7 clocks.
// - Latency register bit 0 enables or disables the delay-locked loop.
`ifndef DILC_REGS_SVH
`define DILC_REGS_SVH
`define DILC_CFG_W 17
`define DILC_CFG_RST 17'h00000
`define DILC_AL_LSB 3
`define DILC_AL_MSB 5
`define DILC_AL_MAX 3'h6
`define DILC_AL_RST 3'h0
`define DILC_CL_LSB 4
`define DILC_CL_MSB 6
`define DILC_CL_MIN 3'h3
`define DILC_CL_RST 3'h3
`define DILC_DLL_DIS_BIT 0
`define DILC_TERM_BIT_A 2
`define DILC_TERM_BIT_B 6
`define DILC_CAL_LSB 7
`define DILC_CAL_MSB 9
`define DILC_CAL_DEFAULT 3'h7
`define DILC_CAL_EXIT 3'h0
`define DILC_REFR_FAST_BIT 7
`define DILC_DLL_RST_BIT 8
`define DILC_PRE_ALL_BIT 10
`define DILC_RSVD_LSB 13
`define DILC_LOCK_CYCLES 8'hC8
`define DILC_PIPE_DEPTH 16
`define DILC_TAP_W 5
`endif

// >>> dilc_top.sv
// Command decoder, configuration registers, latency timing and init tracking
`timescale 1ns/1ps
`include "dilc_regs.svh"
module dilc_top
   import dilc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // Command pins, sampled on the command clock
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [2:0] ba_i,
   input wire logic [15:0] addr_i,
   input wire logic termination_control_i,
   // Command timing strobes
   output logic internal_read_o,
   output logic internal_write_o,
   output logic read_data_start_o,
   output logic write_data_expect_o,
   output logic precharge_all_o,
   output logic refresh_o,
   // Configuration state
   output logic [2:0] posted_delay_o,
   output logic [2:0] read_latency_o,
   output logic [3:0] total_read_delay_o,
   output logic [3:0] write_delay_o,
   output logic dll_enable_o,
   output logic refresh_rate_fast_o,
   output logic driver_impedance_cal_default_o,
   output logic termination_active_o,
   output logic init_ready_o,
   output logic config_error_o
);
   dilc_cmd_e cmd;
   dilc_sel_e sel;
   logic load;
   logic rd_cmd;
   logic wr_cmd;
   logic dll_reset_load;
   logic [`DILC_CFG_W-1:0] load_word;
   logic [2:0] al_field;
   logic [2:0] cl_field;

   // Configuration group
   logic [`DILC_CFG_W-1:0] latency_driver_config;
   logic [`DILC_CFG_W-1:0] refresh_rate_config;
   logic [2:0] posted_delay;
   logic [2:0] read_latency;
   logic [3:0] total_read_delay;
   logic [3:0] write_delay;
   logic config_error;
   logic [`DILC_CFG_W-1:0] next_latency_driver_config;
   logic [`DILC_CFG_W-1:0] next_refresh_rate_config;
   logic [2:0] next_posted_delay;
   logic [2:0] next_read_latency;
   logic [3:0] next_total_read_delay;
   logic [3:0] next_write_delay;
   logic next_config_error;
   logic dll_enable, cal_default;
   logic next_dll_enable, next_cal_default;
   // Init tracking group
   dilc_init_e init_state;
   dilc_init_e next_init_state;
   logic [7:0] lock_cnt;
   logic [7:0] next_lock_cnt;
   logic init_ready;
   logic next_init_ready;
   // Strobe group
   logic precharge_all;
   logic refresh;
   logic termination_active;
   logic next_precharge_all;
   logic next_refresh;
   logic next_termination_active;
   // Decode is gated by the clock gate so a low clock gate reads as NOP
   always_comb begin
      cmd = (!cs_n_i && cke_i) ? dilc_cmd_e'({ras_n_i, cas_n_i, we_n_i}) : CMD_NOP;
      sel = dilc_sel_e'(ba_i[1:0]);
      load = (cmd == CMD_LOAD);
      rd_cmd = (cmd == CMD_READ);
      wr_cmd = (cmd == CMD_WRITE);
      load_word = {ba_i[2], addr_i};
      al_field = addr_i[`DILC_AL_MSB:`DILC_AL_LSB];
      cl_field = addr_i[`DILC_CL_MSB:`DILC_CL_LSB];
      dll_reset_load = load && (sel == SEL_MAIN) && addr_i[`DILC_DLL_RST_BIT];
   end

   // Reserved encodings keep the previous latency and raise a sticky error, except a reserved read latency on a loop reset load
   always_comb begin
      next_latency_driver_config = latency_driver_config;
      next_refresh_rate_config = refresh_rate_config;
      next_posted_delay = posted_delay;
      next_read_latency = read_latency;
      next_config_error = config_error;
      if (load) begin
         if (load_word[`DILC_CFG_W-1:`DILC_RSVD_LSB] != '0) begin
            next_config_error = 1'b1;
         end
         unique case (sel)
            SEL_MAIN: begin
               if (cl_field >= `DILC_CL_MIN) begin
                  next_read_latency = cl_field;
               end else if (!addr_i[`DILC_DLL_RST_BIT]) begin
                  next_config_error = 1'b1;
               end
            end
            SEL_LAT: begin
               next_latency_driver_config = load_word;
               if (al_field <= `DILC_AL_MAX) begin
                  next_posted_delay = al_field;
               end else begin
                  next_config_error = 1'b1;
               end
               if (addr_i[`DILC_CAL_MSB:`DILC_CAL_LSB] != `DILC_CAL_DEFAULT &&
                   addr_i[`DILC_CAL_MSB:`DILC_CAL_LSB] != `DILC_CAL_EXIT) begin
                  next_config_error = 1'b1;
               end
            end
            SEL_REFR: begin
               next_refresh_rate_config = load_word;
               if ((load_word & ~(`DILC_CFG_W'(1) << `DILC_REFR_FAST_BIT)) != '0) begin
                  next_config_error = 1'b1;
               end
            end
            SEL_SPARE: begin
               if (load_word != '0) begin
                  next_config_error = 1'b1;
               end
            end
         endcase
      end
      next_total_read_delay = {1'b0, next_posted_delay} + {1'b0, next_read_latency};
      next_write_delay = next_total_read_delay - 4'h1;
      next_dll_enable = !next_latency_driver_config[`DILC_DLL_DIS_BIT];
      next_cal_default = &next_latency_driver_config[`DILC_CAL_MSB:`DILC_CAL_LSB];
   end
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         latency_driver_config <= `DILC_CFG_RST;
         dll_enable <= 1'b1;
         cal_default <= 1'b0;
         refresh_rate_config <= `DILC_CFG_RST;
         posted_delay <= `DILC_AL_RST;
         read_latency <= `DILC_CL_RST;
         total_read_delay <= {1'b0, `DILC_AL_RST} + {1'b0, `DILC_CL_RST};
         write_delay <= {1'b0, `DILC_AL_RST} + {1'b0, `DILC_CL_RST} - 4'h1;
         config_error <= 1'b0;
      end else begin
         latency_driver_config <= next_latency_driver_config;
         refresh_rate_config <= next_refresh_rate_config;
         posted_delay <= next_posted_delay;
         read_latency <= next_read_latency;
         total_read_delay <= next_total_read_delay;
         write_delay <= next_write_delay;
         config_error <= next_config_error;
         dll_enable <= next_dll_enable;
         cal_default <= next_cal_default;
      end
   end
   // A fresh loop reset always restarts the lock wait, even from ready
   always_comb begin
      next_init_state = init_state;
      next_lock_cnt = lock_cnt;
      unique case (init_state)
         INIT_IDLE: begin
            next_lock_cnt = 8'h00;
         end
         INIT_LOCK: begin
            next_lock_cnt = lock_cnt + 8'h01;
            if (lock_cnt == `DILC_LOCK_CYCLES - 8'h01) begin
               next_init_state = INIT_READY;
            end
         end
         INIT_READY: begin
            next_lock_cnt = lock_cnt;
         end
         default: begin
            next_init_state = INIT_IDLE;
         end
      endcase
      if (dll_reset_load) begin
         next_init_state = INIT_LOCK;
         next_lock_cnt = 8'h00;
      end
      next_init_ready = (next_init_state == INIT_READY);
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_state <= INIT_IDLE;
         lock_cnt <= 8'h00;
         init_ready <= 1'b0;
      end else begin
         init_state <= next_init_state;
         lock_cnt <= next_lock_cnt;
         init_ready <= next_init_ready;
      end
   end

   always_comb begin
      next_precharge_all = (cmd == CMD_PRECHARGE) && addr_i[`DILC_PRE_ALL_BIT];
      next_refresh = (cmd == CMD_REFRESH);
      // Termination stays off until a latency load has enabled it
      next_termination_active = termination_control_i && cke_i &&
         (latency_driver_config[`DILC_TERM_BIT_A] | latency_driver_config[`DILC_TERM_BIT_B]);
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         precharge_all <= 1'b0;
         refresh <= 1'b0;
         termination_active <= 1'b0;
      end else begin
         precharge_all <= next_precharge_all;
         refresh <= next_refresh;
         termination_active <= next_termination_active;
      end
   end

   // Taps are read live; reloading latency with a burst in flight is unsafe
   dilc_delay_line #(.DEPTH(`DILC_PIPE_DEPTH), .TAP_W(`DILC_TAP_W)) u_read_line (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .pulse_i(rd_cmd),
      .tap_a_i({2'b00, posted_delay} + `DILC_TAP_W'(1)),
      .tap_b_i({1'b0, total_read_delay}),
      .out_a_o(internal_read_o),
      .out_b_o(read_data_start_o)
   );

   dilc_delay_line #(.DEPTH(`DILC_PIPE_DEPTH), .TAP_W(`DILC_TAP_W)) u_write_line (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .pulse_i(wr_cmd),
      .tap_a_i({2'b00, posted_delay} + `DILC_TAP_W'(1)),
      .tap_b_i({1'b0, write_delay}),
      .out_a_o(internal_write_o),
      .out_b_o(write_data_expect_o)
   );

   assign precharge_all_o = precharge_all;
   assign refresh_o = refresh;
   assign posted_delay_o = posted_delay;
   assign read_latency_o = read_latency;
   assign total_read_delay_o = total_read_delay;
   assign write_delay_o = write_delay;
   assign dll_enable_o = dll_enable;
   assign refresh_rate_fast_o = refresh_rate_config[`DILC_REFR_FAST_BIT];
   assign driver_impedance_cal_default_o = cal_default;
   assign termination_active_o = termination_active;
   assign init_ready_o = init_ready;
   assign config_error_o = config_error;
   // Cycles since the last loop reset load, for checking only
   logic [7:0] since_rst;
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         since_rst <= 8'h00;
      end else if (dll_reset_load) begin
         since_rst <= 8'h00;
      end else if (since_rst != 8'hFF) begin
         since_rst <= since_rst + 8'h01;
      end
   end
   a_al_range: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      posted_delay_o <= 3'h6) else $error("posted delay out of range");
   a_al_load: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (load && sel == SEL_LAT && al_field <= 3'h6) |=> posted_delay_o == $past(al_field))
      else $error("posted delay not taken from load");
   a_internal_issue: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (rd_cmd && !load && posted_delay_o == 3'h2) |-> !internal_read_o [*3] ##1 internal_read_o)
      else $error("internal read not issued after posted delay");
   a_rd_total_delay: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (rd_cmd && total_read_delay_o == 4'h5) |-> ##5 read_data_start_o)
      else $error("read data start late or early");
   a_wr_delay: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_cmd && write_delay_o == 4'h4) |-> ##4 write_data_expect_o)
      else $error("write data expect misplaced");
   a_wr_rd_gap: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      write_delay_o == total_read_delay_o - 4'h1) else $error("write delay not one less");
   a_ready_wait: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      $rose(init_ready_o) |-> since_rst == 8'hC8) else $error("ready not 200 clocks after reset");
   a_ready_lock: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      dll_reset_load |=> !init_ready_o [*8]) else $error("ready during loop lock");
   a_prech_all: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (cmd == CMD_PRECHARGE) |=> precharge_all_o == $past(addr_i[10]))
      else $error("precharge all mismatch");
   a_cl_range: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (load && sel == SEL_MAIN && !addr_i[`DILC_DLL_RST_BIT] && cl_field < 3'h3) |=>
      $stable(read_latency_o) && config_error_o) else $error("reserved read latency accepted");
   a_dll_enable: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (load && sel == SEL_LAT) |=> dll_enable_o == !$past(addr_i[0]))
      else $error("loop enable not taken from bit 0");
   a_latency_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      !load |=> $stable(posted_delay_o) && $stable(read_latency_o))
      else $error("latency changed without load");
endmodule
